// ### dv/bsil_scan_bench.sv
`timescale 1ns/1ns
`default_nettype none
// self-checking bench for the scan instruction logic
module bsil_scan_bench;
  import bsil_pkg::*;
  // one row: instruction code shifted in and the decode it should give
  typedef struct packed {logic [3:0] code; bsil_instr_t ins;} bsil_row_t;
  bsil_row_t rows [16] = '{
    '{4'h0, BSIL_EXTEST}, '{4'h1, BSIL_BYPASS}, '{4'h2, BSIL_BYPASS}, '{4'h3, BSIL_BYPASS},
    '{4'h4, BSIL_SAMPLE}, '{4'h5, BSIL_BYPASS}, '{4'h6, BSIL_BYPASS}, '{4'h7, BSIL_BYPASS},
    '{4'h8, BSIL_BYPASS}, '{4'h9, BSIL_BYPASS}, '{4'hA, BSIL_BYPASS}, '{4'hB, BSIL_BYPASS},
    '{4'hC, BSIL_BYPASS}, '{4'hD, BSIL_BYPASS}, '{4'hE, BSIL_BYPASS}, '{4'hF, BSIL_BYPASS}};
  // clock, reset and design pins
  logic i_clk_sys, i_rst_b, tck, tms, tdi, o_tdo, o_tdo_oe_b, i_video_output_enable, o_video_output_bus_oe_b;
  logic [3:0] i_func_in, i_mission_out, o_func_out;
  logic [7:0] i_mission_video_q, o_video_output_bus;
  bsil_tap_t o_tap_state;
  bsil_instr_t o_instr;
  // bench bookkeeping
  int n_fail = 0;
  int total_checks = 0;
  int cycles = 0;
  logic [31:0] dout;
  logic d;

  bsil_scan #(.N_IN(4), .N_OUT(4), .VQ_W(8)) bsil_scan_i (
    .i_clk_sys(i_clk_sys), .i_rst_b(i_rst_b), .i_tck(tck), .i_tms(tms), .i_tdi(tdi),
    .o_tdo(o_tdo), .o_tdo_oe_b(o_tdo_oe_b), .i_func_in(i_func_in),
    .i_video_output_enable(i_video_output_enable), .i_mission_out(i_mission_out),
    .i_mission_video_q(i_mission_video_q), .o_func_out(o_func_out),
    .o_video_output_bus(o_video_output_bus), .o_video_output_bus_oe_b(o_video_output_bus_oe_b),
    .o_tap_state(o_tap_state), .o_instr(o_instr));

  bsil_tester bsil_tester_i (.o_tck(tck), .o_tms(tms), .o_tdi(tdi), .i_tdo(o_tdo));

  // system clock
  initial begin
    i_clk_sys = 1'b0;
    forever #10 i_clk_sys = ~i_clk_sys;
  end

  // cut a hang short
  always @(posedge i_clk_sys) begin
    cycles++;
    if (cycles == 20000) begin
      n_fail++;
      results();
    end
  end

  // verdict and end of run
  task automatic results();
    if (n_fail == 0 && total_checks > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask

  // compare and count
  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp) begin
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
      n_fail++;
    end
  endtask

  // pins as one word: oe_b, video bus, output pins
  task automatic pins(input logic [12:0] e);
    check({19'h0, o_video_output_bus_oe_b, o_video_output_bus, o_func_out}, {19'h0, e});
  endtask

  // let the crossing settle, then sample off the edge
  task automatic wait_sys(input int n);
    repeat (n) @(posedge i_clk_sys);
    #1;
  endtask

  initial begin
    i_rst_b = 1'b0;
    i_func_in = 4'h0;
    i_video_output_enable = 1'b0;
    i_mission_out = 4'h0;
    i_mission_video_q = 8'h00;
    // test clock ticks while reset is held
    fork
      bsil_tester_i.tlr();
      repeat (10) @(posedge i_clk_sys);
    join
    pins(13'h1000);
    check({30'h0, o_instr}, {30'h0, BSIL_BYPASS});
    check({31'h0, o_tdo_oe_b}, 32'h1);
    @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    i_func_in <= 4'hA;
    i_video_output_enable <= 1'b1;
    i_mission_out <= 4'h6;
    i_mission_video_q <= 8'hC3;
    bsil_tester_i.step(1'b0, 1'b1, d);
    wait_sys(12);
    pins(13'h0C36);
    // every instruction code through the table
    foreach (rows[k]) begin
      bsil_tester_i.scan(1'b1, 4, {28'h0, rows[k].code}, dout);
      check(dout, 32'h9);
      check({30'h0, o_instr}, {30'h0, rows[k].ins});
      check({28'h0, o_tap_state}, {28'h0, BSIL_RTI});
    end
    // bypass is a single stage cleared at capture
    bsil_tester_i.scan(1'b0, 9, 32'h0A5, dout);
    check(dout, 32'h14A);
    // sample/preload: inputs captured, pins untouched
    bsil_tester_i.scan(1'b1, 4, 32'h4, dout);
    bsil_tester_i.scan(1'b0, 17, 32'h13C50, dout);
    check(dout & 32'h1000F, 32'h1000A);
    wait_sys(12);
    pins(13'h0C36);
    // extest drives the preloaded cells
    bsil_tester_i.scan(1'b1, 4, 32'h0, dout);
    wait_sys(12);
    pins(13'h03C5);
    bsil_tester_i.scan(1'b0, 17, 32'h00AA0, dout);
    check(dout & 32'h1FFFF, 32'h13C5A);
    wait_sys(12);
    pins(13'h10AA);
    // reset state of the controller forces bypass and frees the pins
    bsil_tester_i.tlr();
    check({28'h0, o_tap_state}, {28'h0, BSIL_TLR});
    check({30'h0, o_instr}, {30'h0, BSIL_BYPASS});
    wait_sys(12);
    pins(13'h0C36);
    // reset in mid-run while extest drives the pins
    bsil_tester_i.step(1'b0, 1'b1, d);
    bsil_tester_i.scan(1'b1, 4, 32'h0, dout);
    wait_sys(12);
    pins(13'h10AA);
    @(posedge i_clk_sys);
    i_rst_b <= 1'b0;
    bsil_tester_i.tlr();
    pins(13'h1000);
    check({30'h0, o_instr}, {30'h0, BSIL_BYPASS});
    @(posedge i_clk_sys);
    i_rst_b <= 1'b1;
    wait_sys(12);
    pins(13'h0C36);
    results();
  end
endmodule
`default_nettype wire

// ### dv/bsil_tester.sv
`timescale 1ns/1ns
`default_nettype none
// behavioural board tester: owns the test clock and steers the controller
module bsil_tester (
  // test port towards the device
  output logic o_tck,
  output logic o_tms,
  output logic o_tdi,
  input wire logic i_tdo
);
  // clock stands low and tdi sits at its pull-up level between frames
  initial begin
    o_tck = 1'b0;
    o_tms = 1'b1;
    o_tdi = 1'b1;
  end

  // one test clock period: present tms/tdi while low, sample tdo before the rise
  task automatic step(input logic tms, input logic tdi, output logic tdo);
    o_tms = tms;
    o_tdi = tdi;
    #24;
    tdo = i_tdo;
    o_tck = 1'b1;
    #24;
    o_tck = 1'b0;
  endtask

  // five ones reach the reset state from anywhere
  task automatic tlr();
    logic d;
    repeat (5) step(1'b1, 1'b1, d);
  endtask

  // shift n bits lsb first starting and ending in run-test/idle
  task automatic scan(input logic ir, input int n, input logic [31:0] din, output logic [31:0] dout);
    logic d;
    dout = '0;
    step(1'b1, 1'b1, d);
    // second select step leads to the instruction path
    if (ir) step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
    step(1'b0, 1'b1, d);
    // last bit leaves the shift state with tms high
    for (int i = 0; i < n; i++) begin
      step(i == n - 1, din[i], d);
      dout[i] = d;
    end
    // update then back to idle, tdi released to its pull-up level
    step(1'b1, 1'b1, d);
    step(1'b0, 1'b1, d);
  endtask
endmodule
`default_nettype wire

// ### logic/bsil_defines.svh
`ifndef BSIL_DEFINES_SVH
`define BSIL_DEFINES_SVH

// instruction register geometry and codes
`define BSIL_IR_W 4
`define BSIL_IR_EXTEST 4'h0
`define BSIL_IR_SAMPLE 4'h4
`define BSIL_IR_CAPTURE 4'h9
`define BSIL_IR_RESET 4'hF

// widths of the functional pin groups
`define BSIL_VQ_W 8
`define BSIL_N_IN 4
`define BSIL_N_OUT 4

`endif

// ### logic/bsil_pkg.sv
package bsil_pkg;

  // tap controller states, gray-coded around the usual loop
  typedef enum logic [3:0] {
    BSIL_TLR    = 4'h0,
    BSIL_RTI    = 4'h1,
    BSIL_SEL_DR = 4'h3,
    BSIL_CAP_DR = 4'h2,
    BSIL_SH_DR  = 4'h6,
    BSIL_EX1_DR = 4'h7,
    BSIL_PA_DR  = 4'h5,
    BSIL_EX2_DR = 4'h4,
    BSIL_UP_DR  = 4'hC,
    BSIL_SEL_IR = 4'hD,
    BSIL_CAP_IR = 4'hF,
    BSIL_SH_IR  = 4'hE,
    BSIL_EX1_IR = 4'hA,
    BSIL_PA_IR  = 4'hB,
    BSIL_EX2_IR = 4'h9,
    BSIL_UP_IR  = 4'h8
  } bsil_tap_t;

  // decoded active instruction
  typedef enum logic [1:0] {
    BSIL_BYPASS = 2'h0,
    BSIL_SAMPLE = 2'h1,
    BSIL_EXTEST = 2'h3
  } bsil_instr_t;

endpackage

// ### logic/bsil_scan.sv
`include "bsil_defines.svh"
`timescale 1ns/1ns
`default_nettype none
module bsil_scan #(
  parameter int N_IN = `BSIL_N_IN,
  parameter int N_OUT = `BSIL_N_OUT,
  parameter int VQ_W = `BSIL_VQ_W
) (
  // system clock and reset
  input wire logic i_clk_sys,
  input wire logic i_rst_b,
  // test port from the tester
  input wire logic i_tck,
  input wire logic i_tms,
  input wire logic i_tdi,
  output logic o_tdo,
  output logic o_tdo_oe_b,
  // functional input pins
  input wire logic [N_IN-1:0] i_func_in,
  input wire logic i_video_output_enable,
  // mission logic values for the output pins
  input wire logic [N_OUT-1:0] i_mission_out,
  input wire logic [VQ_W-1:0] i_mission_video_q,
  // functional output pins
  output logic [N_OUT-1:0] o_func_out,
  output logic [VQ_W-1:0] o_video_output_bus,
  output logic o_video_output_bus_oe_b,
  // debug view of the controller
  output bsil_pkg::bsil_tap_t o_tap_state,
  output bsil_pkg::bsil_instr_t o_instr
);
  import bsil_pkg::*;

  // chain length and update-latch width
  localparam int UW = 1 + VQ_W + N_OUT;
  localparam int L = UW + N_IN;

  // state moved on the rising test-clock edge
  typedef struct packed {
    logic [`BSIL_IR_W-1:0] ir_sh; // instruction shift stage
    logic bypass; // one-stage bypass register
    logic [L-1:0] bsr; // boundary shift stages, bit 0 at tdo
  } bsil_rise_t;

  // state moved on the falling test-clock edge
  typedef struct packed {
    logic [`BSIL_IR_W-1:0] ir_hold; // active instruction
    logic [UW-1:0] upd; // update latches {oe, video, outputs}
    logic tdo; // serial output
    logic tdo_oe_b; // serial output enable, low drives
    logic tog; // flips on every latch change
  } bsil_fall_t;

  // state on the system clock
  typedef struct packed {
    logic tog_seen; // last toggle consumed
    logic extest; // extest seen by the pin side
    logic [UW-1:0] lat; // copy of the update latches
    logic [N_OUT-1:0] func_out; // output pin values
    logic [VQ_W-1:0] vq; // video bus values
    logic vq_oe_b; // video bus enable, low drives
  } bsil_sys_t;

  bsil_rise_t rise_r;
  bsil_rise_t rise_nxt;
  bsil_fall_t fall_r;
  bsil_fall_t fall_nxt;
  bsil_sys_t sys_r;
  bsil_sys_t sys_nxt;
  bsil_tap_t tap_state; // controller state
  bsil_instr_t instr; // decoded active instruction
  logic bsr_sel; // boundary register in the path
  logic [L-1:0] cap_vec; // values taken at capture-dr
  logic tog_s; // toggle seen on the system clock
  logic voe_s; // output-enable pin on the system clock

  // code to instruction, anything unlisted is bypass
  function automatic bsil_instr_t bsil_decode(input logic [`BSIL_IR_W-1:0] code);
    case (code)
      `BSIL_IR_EXTEST: return BSIL_EXTEST;
      `BSIL_IR_SAMPLE: return BSIL_SAMPLE;
      default: return BSIL_BYPASS;
    endcase
  endfunction

  // controller stepped by mode select
  bsil_tap u_tap (
    .i_tck(i_tck),
    .i_rst_b(i_rst_b),
    .i_tms(i_tms),
    .o_state(tap_state)
  );

  // latch toggle into the system domain
  bsil_sync #(.W(1)) u_sync_tog (
    .i_clk(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async(fall_r.tog),
    .o_sync(tog_s)
  );

  // video output-enable pin into the system domain
  bsil_sync #(.W(1)) u_sync_voe (
    .i_clk(i_clk_sys),
    .i_rst_b(i_rst_b),
    .i_async(i_video_output_enable),
    .o_sync(voe_s)
  );

  // decode of the held instruction
  always_comb begin
    instr = bsil_decode(fall_r.ir_hold);
    bsr_sel = (instr != BSIL_BYPASS);
    // oe cell takes its pin, output cells read back their latches
    cap_vec = {i_video_output_enable, fall_r.upd[UW-2:0], i_func_in};
  end

  // rising-edge shift and capture
  always_comb begin
    rise_nxt = rise_r;
    case (tap_state)
      // fixed pattern on capture
      BSIL_CAP_IR: begin
        rise_nxt.ir_sh = `BSIL_IR_CAPTURE;
      end
      // tdi into the msb, lsb falls toward tdo
      BSIL_SH_IR: begin
        rise_nxt.ir_sh = {i_tdi, rise_r.ir_sh[`BSIL_IR_W-1:1]};
      end
      // pin capture for sample and extest alike
      BSIL_CAP_DR: begin
        if (bsr_sel) begin
          rise_nxt.bsr = cap_vec;
        end else begin
          rise_nxt.bypass = 1'b0;
        end
      end
      // shift the selected data register
      BSIL_SH_DR: begin
        if (bsr_sel) begin
          rise_nxt.bsr = {i_tdi, rise_r.bsr[L-1:1]};
        end else begin
          rise_nxt.bypass = i_tdi;
        end
      end
      // other states hold
      default: begin
      end
    endcase
  end

  // register rising-edge state
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      rise_r <= '0;
    end else begin
      rise_r <= rise_nxt;
    end
  end

  // falling-edge update, tdo and holding latch
  always_comb begin
    fall_nxt = fall_r;
    fall_nxt.tdo_oe_b = 1'b1;
    case (tap_state)
      // reset state forces bypass
      BSIL_TLR: begin
        if (fall_r.ir_hold != `BSIL_IR_RESET) begin
          fall_nxt.ir_hold = `BSIL_IR_RESET;
          fall_nxt.tog = ~fall_r.tog;
        end
      end
      // instruction lsb out on tdo
      BSIL_SH_IR: begin
        fall_nxt.tdo = rise_r.ir_sh[0];
        fall_nxt.tdo_oe_b = 1'b0;
      end
      // data register lsb out on tdo
      BSIL_SH_DR: begin
        fall_nxt.tdo = bsr_sel ? rise_r.bsr[0] : rise_r.bypass;
        fall_nxt.tdo_oe_b = 1'b0;
      end
      // shift stage becomes the active instruction
      BSIL_UP_IR: begin
        fall_nxt.ir_hold = rise_r.ir_sh;
        fall_nxt.tog = ~fall_r.tog;
      end
      // output cells into their update latches
      BSIL_UP_DR: begin
        if (bsr_sel) begin
          fall_nxt.upd = rise_r.bsr[L-1:N_IN];
          fall_nxt.tog = ~fall_r.tog;
        end
      end
      // other states hold
      default: begin
      end
    endcase
  end

  // register falling-edge state
  always_ff @(negedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      fall_r.ir_hold <= `BSIL_IR_RESET;
      fall_r.upd <= '0;
      fall_r.tdo <= 1'b0;
      fall_r.tdo_oe_b <= 1'b1;
      fall_r.tog <= 1'b0;
    end else begin
      fall_r <= fall_nxt;
    end
  end

  // pin side: take latches on a toggle, then steer the pins
  always_comb begin
    sys_nxt = sys_r;
    // test-domain words are stable once the toggle is seen
    if (tog_s != sys_r.tog_seen) begin
      sys_nxt.tog_seen = tog_s;
      sys_nxt.extest = (instr == BSIL_EXTEST);
      sys_nxt.lat = fall_r.upd;
    end
    if (sys_r.extest) begin
      // latches own the pins and the video enable
      sys_nxt.func_out = sys_r.lat[N_OUT-1:0];
      sys_nxt.vq = sys_r.lat[UW-2 -: VQ_W];
      sys_nxt.vq_oe_b = ~sys_r.lat[UW-1];
    end else begin
      // mission logic and the pin own them
      sys_nxt.func_out = i_mission_out;
      sys_nxt.vq = i_mission_video_q;
      sys_nxt.vq_oe_b = ~voe_s;
    end
  end

  // register pin-side state
  always_ff @(posedge i_clk_sys or negedge i_rst_b) begin
    if (!i_rst_b) begin
      sys_r.tog_seen <= 1'b0;
      sys_r.extest <= 1'b0;
      sys_r.lat <= '0;
      sys_r.func_out <= '0;
      sys_r.vq <= '0;
      sys_r.vq_oe_b <= 1'b1;
    end else begin
      sys_r <= sys_nxt;
    end
  end

  // port drive
  assign o_tdo = fall_r.tdo;
  assign o_tdo_oe_b = fall_r.tdo_oe_b;
  assign o_func_out = sys_r.func_out;
  assign o_video_output_bus = sys_r.vq;
  assign o_video_output_bus_oe_b = sys_r.vq_oe_b;
  assign o_tap_state = tap_state;
  assign o_instr = instr;

  // capture-ir loads the fixed pattern
  ir_capture_a: assert property (@(posedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_CAP_IR |=> rise_r.ir_sh == 4'h9)
    else $error("capture-ir pattern wrong");

  // shift-ir moves one place with tdi at the msb
  ir_shift_a: assert property (@(posedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_SH_IR |=> rise_r.ir_sh == {$past(i_tdi), $past(rise_r.ir_sh[3:1])})
    else $error("instruction shift wrong");

  // instruction stage still outside capture and shift
  ir_still_a: assert property (@(posedge i_tck) disable iff (!i_rst_b)
    !(tap_state inside {BSIL_CAP_IR, BSIL_SH_IR}) |=> $stable(rise_r.ir_sh))
    else $error("instruction stage moved outside shift");

  // unlisted codes decode as bypass
  decode_bypass_a: assert property (@(posedge i_tck) disable iff (!i_rst_b)
    (fall_r.ir_hold != 4'h0 && fall_r.ir_hold != 4'h4) |-> instr == BSIL_BYPASS && !bsr_sel)
    else $error("bypass decode wrong");

  // all ones scanned in leaves bypass active
  ones_bypass_a: assert property (@(negedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_UP_IR && rise_r.ir_sh == 4'hF |=> instr == BSIL_BYPASS)
    else $error("all ones did not select bypass");

  // bypass is exactly one stage deep
  bypass_len_a: assert property (@(posedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_SH_DR && !bsr_sel |=> rise_r.bypass == $past(i_tdi))
    else $error("bypass stage wrong");

  // capture-dr takes the input pins
  capture_dr_a: assert property (@(posedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_CAP_DR && bsr_sel |=> rise_r.bsr[N_IN-1:0] == $past(i_func_in))
    else $error("input pins not captured");

  // update-dr copies output cells on the falling edge
  update_dr_a: assert property (@(negedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_UP_DR && bsr_sel |=> fall_r.upd == $past(rise_r.bsr[L-1:N_IN]))
    else $error("update latches not loaded");

  // tdo is driven after every falling edge in a shift state
  tdo_drive_a: assert property (@(negedge i_tck) disable iff (!i_rst_b)
    tap_state inside {BSIL_SH_IR, BSIL_SH_DR} |=> !o_tdo_oe_b)
    else $error("tdo not driven in shift");

  // tdo is released outside the shift states so the chain can be shared
  tdo_release_a: assert property (@(negedge i_tck) disable iff (!i_rst_b)
    !(tap_state inside {BSIL_SH_IR, BSIL_SH_DR}) |=> o_tdo_oe_b)
    else $error("tdo driven outside shift");

  // outside extest the pins follow mission logic
  // the sampled reset keeps the release edge out, where the pins still hold their reset value
  mission_pins_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    i_rst_b && !sys_r.extest |=> o_func_out == $past(i_mission_out) && o_video_output_bus == $past(i_mission_video_q))
    else $error("mission logic lost the pins");

  // under extest latches drive pins and the video enable
  extest_pins_a: assert property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    sys_r.extest |=> o_func_out == $past(sys_r.lat[N_OUT-1:0]) && o_video_output_bus_oe_b == !$past(sys_r.lat[UW-1]))
    else $error("extest pins not from latches");

  // main scenarios
  cover_sample_c: cover property (@(posedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_CAP_DR && instr == BSIL_SAMPLE);
  cover_extest_c: cover property (@(negedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_UP_DR && instr == BSIL_EXTEST);
  cover_bypass_c: cover property (@(posedge i_tck) disable iff (!i_rst_b)
    tap_state == BSIL_SH_DR && instr == BSIL_BYPASS);
  cover_pins_c: cover property (@(posedge i_clk_sys) disable iff (!i_rst_b)
    sys_r.extest && !o_video_output_bus_oe_b);

endmodule
`default_nettype wire

// ### logic/bsil_sync.sv
`timescale 1ns/1ns
`default_nettype none
module bsil_sync #(
  parameter int W = 1
) (
  // clock and reset of the receiving domain
  input wire logic i_clk,
  input wire logic i_rst_b,
  // foreign level in, filtered level out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  // three stages plus the accepted value
  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
    logic [W-1:0] s3;
    logic [W-1:0] q;
  } bsil_sync_t;

  bsil_sync_t st_r;
  bsil_sync_t st_nxt;
  logic [W-1:0] agree;

  // a bit is accepted only when stages two and three agree
  always_comb begin
    st_nxt = st_r;
    agree = ~(st_r.s2 ^ st_r.s3);
    st_nxt.s1 = i_async;
    st_nxt.s2 = st_r.s1;
    st_nxt.s3 = st_r.s2;
    st_nxt.q = (st_r.s3 & agree) | (st_r.q & ~agree);
  end

  // register the state
  always_ff @(posedge i_clk or negedge i_rst_b) begin
    if (!i_rst_b) begin
      st_r <= '0;
    end else begin
      st_r <= st_nxt;
    end
  end

  assign o_sync = st_r.q;

endmodule
`default_nettype wire

// ### logic/bsil_tap.sv
`timescale 1ns/1ns
`default_nettype none
module bsil_tap (
  // test clock and reset
  input wire logic i_tck,
  input wire logic i_rst_b,
  // mode select from the tester
  input wire logic i_tms,
  // current controller state
  output bsil_pkg::bsil_tap_t o_state
);
  import bsil_pkg::*;

  // controller state record
  typedef struct packed {
    bsil_tap_t state;
  } bsil_tapst_t;

  bsil_tapst_t tap_r;
  bsil_tapst_t tap_nxt;

  // sixteen-state walk steered by mode select
  always_comb begin
    tap_nxt = tap_r;
    case (tap_r.state)
      BSIL_TLR: tap_nxt.state = i_tms ? BSIL_TLR : BSIL_RTI;
      BSIL_RTI: tap_nxt.state = i_tms ? BSIL_SEL_DR : BSIL_RTI;
      BSIL_SEL_DR: tap_nxt.state = i_tms ? BSIL_SEL_IR : BSIL_CAP_DR;
      BSIL_CAP_DR: tap_nxt.state = i_tms ? BSIL_EX1_DR : BSIL_SH_DR;
      BSIL_SH_DR: tap_nxt.state = i_tms ? BSIL_EX1_DR : BSIL_SH_DR;
      BSIL_EX1_DR: tap_nxt.state = i_tms ? BSIL_UP_DR : BSIL_PA_DR;
      BSIL_PA_DR: tap_nxt.state = i_tms ? BSIL_EX2_DR : BSIL_PA_DR;
      BSIL_EX2_DR: tap_nxt.state = i_tms ? BSIL_UP_DR : BSIL_SH_DR;
      BSIL_UP_DR: tap_nxt.state = i_tms ? BSIL_SEL_DR : BSIL_RTI;
      BSIL_SEL_IR: tap_nxt.state = i_tms ? BSIL_TLR : BSIL_CAP_IR;
      BSIL_CAP_IR: tap_nxt.state = i_tms ? BSIL_EX1_IR : BSIL_SH_IR;
      BSIL_SH_IR: tap_nxt.state = i_tms ? BSIL_EX1_IR : BSIL_SH_IR;
      BSIL_EX1_IR: tap_nxt.state = i_tms ? BSIL_UP_IR : BSIL_PA_IR;
      BSIL_PA_IR: tap_nxt.state = i_tms ? BSIL_EX2_IR : BSIL_PA_IR;
      BSIL_EX2_IR: tap_nxt.state = i_tms ? BSIL_UP_IR : BSIL_SH_IR;
      BSIL_UP_IR: tap_nxt.state = i_tms ? BSIL_SEL_DR : BSIL_RTI;
      default: tap_nxt.state = BSIL_TLR;
    endcase
  end

  // register the state
  always_ff @(posedge i_tck or negedge i_rst_b) begin
    if (!i_rst_b) begin
      tap_r.state <= BSIL_TLR;
    end else begin
      tap_r <= tap_nxt;
    end
  end

  assign o_state = tap_r.state;

  // five ones on mode select always land in test-logic-reset
  tap_reset_a: assert property (@(posedge i_tck) disable iff (!i_rst_b)
    i_tms [*5] |=> tap_r.state == BSIL_TLR)
    else $error("tap did not reach reset after five ones");

endmodule
`default_nettype wire
